// ===== src/sense_amplifier_control.sv
`timescale 1ns/1ps

// Summary of operation
// - Each amplifier is switched off alone when its enable bit is zero.
// - Amplifiers and comparators can each be disabled to save current.
// - A comparator with an all-zero threshold field counts as disabled.
// - Each amplifier's own gain field picks 5, 10, 20 or 40 V/V.
// - Sample-hold path opens only while that amplifier's own enable is one.
// - Enabled amplifiers with their sample-hold bit set sample together while the shared strobe is low.
// - Back-EMF enabled keeps the third amplifier's sample switch open.
// - Without back-EMF, codes 100 and 111 route amplifier three out.
// - An offset calibration runs by itself after power-up.
// - Setting one amplifier's calibrate bit calibrates that amplifier only.
// - Connect bit zero: switches 1,2 open, 3,4 closed during auto-zero.
// - Connect bit one: switches 1,2 stay closed during auto-zero.
// - A calibration lasts about 288 us; caller waits 400 us per amplifier.
// - Each amplifier input is watched against a selectable overcurrent level.
// - Floating phase is picked at strobe fall or from comparator outputs.
// - Select field steers supply, temperature or back-EMF onto the pin.
// - Codes: 000 ground, 001 supply, 010 temp, 011 ref, 101/110 amps.
module sense_amplifier_control
   import sense_ctrl_pkg::*;
#(
   parameter int CAL_CYCLES = CAL_CYCLES_DEF
) (
   input  wire logic              core_clk_i,
   input  wire logic              rstn_i,
   input  wire logic [ADDR_W-1:0] avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output logic      [31:0]       avs_readdata_o,
   output logic                   avs_waitrequest_o,
   input  wire logic              sample_strobe_n_i,
   input  wire logic [2:0]        comparator_out_i,
   input  wire logic [2:0]        overcurrent_raw_i,
   input  wire logic [2:0]        high_in_i,
   input  wire logic [2:0]        low_in_i,
   input  wire logic              sleep_i,
   output logic      [2:0]        amp_enable_o,
   output logic      [5:0]        amp_gain_sel_o,
   output logic      [2:0]        sample_switch_o,
   output logic      [2:0]        shunt_switch_o,
   output logic      [2:0]        ground_switch_o,
   output logic      [2:0]        autozero_o,
   output logic      [2:0]        comparator_enable_o,
   output logic      [11:0]       comparator_threshold_o,
   output logic      [1:0]        overcurrent_threshold_sel_o,
   output pin_src_t               monitor_source_o,
   output logic                   monitor_series_res_o,
   output logic      [1:0]        floating_phase_o
);

   localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CAL_CYCLES - 1);

   state_t st;
   state_t nx;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [1:0] first_set(input logic [2:0] v);
      logic [1:0] r;
      r = PHASE_A;
      if (v[0]) begin
         r = PHASE_A;
      end else if (v[1]) begin
         r = PHASE_B;
      end else if (v[2]) begin
         r = PHASE_C;
      end
      return r;
   endfunction

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      logic       acc_wr;
      logic [2:0] cal_set;
      logic [2:0] cal_clr;
      logic [2:0] oc_clr;
      logic       fall;
      logic       sleeping;
      logic [31:0] mrg;
      nx       = st;
      mrg      = '0;
      cal_set  = 3'h0;
      cal_clr  = 3'h0;
      oc_clr   = 3'h0;
      acc_wr   = avs_write_i && !st.wait_r;
      nx.s1    = {sleep_i, low_in_i, high_in_i, overcurrent_raw_i,
                  comparator_out_i, sample_strobe_n_i};
      nx.s2    = st.s1;
      nx.strobe_q = st.s2.strobe_n;
      sleeping = st.s2.sleep;
      fall     = st.strobe_q && !st.s2.strobe_n;

      // One wait cycle on every access, then a one-cycle answer.
      nx.wait_r = !((avs_read_i || avs_write_i) && st.wait_r);
      if (avs_read_i && st.wait_r) begin
         if (avs_address_i == OFS_AMP_CTRL) begin
            nx.rdata = 32'(st.amp);
         end else if (avs_address_i == OFS_SENSE) begin
            nx.rdata = 32'(st.cfg);
         end else if (avs_address_i == OFS_CAL) begin
            nx.rdata = 32'({st.cst == CAL_RUN, st.cur, st.pending});
         end else if (avs_address_i == OFS_STATUS) begin
            nx.rdata = 32'({st.phase, st.oc_flag, st.s2.cmp});
         end else begin
            nx.rdata = RD_UNMAPPED;
         end
      end

      if (acc_wr) begin
         if (avs_address_i == OFS_AMP_CTRL) begin
            mrg    = merge(32'(st.amp), avs_writedata_i, avs_byteenable_i);
            nx.amp = amp_ctrl_t'(mrg[$bits(amp_ctrl_t)-1:0]);
         end else if (avs_address_i == OFS_SENSE) begin
            mrg    = merge(32'(st.cfg), avs_writedata_i, avs_byteenable_i);
            nx.cfg = sense_cfg_t'(mrg[$bits(sense_cfg_t)-1:0]);
         end else if (avs_address_i == OFS_CAL) begin
            if (avs_byteenable_i[0]) begin
               cal_set = avs_writedata_i[2:0];
            end
         end else if (avs_address_i == OFS_STATUS) begin
            if (avs_byteenable_i[0]) begin
               oc_clr = avs_writedata_i[5:3];
            end
         end
      end

      // A new overcurrent event outweighs a clear in the same cycle.
      nx.oc_flag = (st.oc_flag & ~oc_clr) | st.s2.oc;

      // Floating phase for the back-EMF chain.
      if (st.cfg.phase_src) begin
         if (st.s2.cmp[1:0] != 2'h3) begin
            nx.phase = {st.s2.cmp[0], st.s2.cmp[1]};
         end
      end else if (fall) begin
         nx.phase = first_set(~(st.s2.hi | st.s2.li));
      end

      // Calibration sequencer; one amplifier at a time, lowest first.
      case (st.cst)
         CAL_IDLE: begin
            if (st.pending != 3'h0 && !sleeping) begin
               nx.cst = CAL_RUN;
               nx.cur = first_set(st.pending);
               nx.cnt = '0;
            end
         end
         CAL_RUN: begin
            nx.cnt = st.cnt + 1'b1;
            if (st.cnt == CAL_LAST) begin
               nx.cst = CAL_IDLE;
               cal_clr[st.cur] = 1'b1;
            end
         end
         default: nx.cst = CAL_IDLE;
      endcase
      nx.pending = (st.pending & ~cal_clr) | cal_set;

      // Settings fall back to reset values while the device sleeps.
      if (sleeping) begin
         nx.amp     = AMP_CTRL_RST;
         nx.cfg     = SENSE_RST;
         nx.oc_flag = 3'h0;
         nx.pending = PENDING_RST;
         nx.cst     = CAL_IDLE;
      end

      // Registered outputs.
      nx.out.amp_en = st.amp.enable;
      nx.out.gain   = st.amp.gain;
      nx.out.oc_th  = st.cfg.oc_th;
      nx.out.cmp_th = st.cfg.cmp_th;
      nx.out.phase  = st.phase;
      for (int i = 0; i < 3; i++) begin
         nx.out.cmp_en[i] = st.cfg.cmp_th[i] != CMP_TH_OFF;
         nx.out.sample_sw[i] = st.amp.enable[i] && st.amp.sh_en[i]
                               && !st.s2.strobe_n;
         if (st.cst == CAL_RUN && st.cur == 2'(i)) begin
            nx.out.sw12[i]     = st.amp.cal_connect;
            nx.out.sw34[i]     = !st.amp.cal_connect;
            nx.out.autozero[i] = 1'b1;
         end else begin
            nx.out.sw12[i]     = 1'b1;
            nx.out.sw34[i]     = 1'b0;
            nx.out.autozero[i] = 1'b0;
         end
      end
      if (st.amp.backemf_enable) begin
         nx.out.sample_sw[AMP3_IDX] = 1'b0;
      end

      // Output pin multiplexer.
      nx.out.series_res = st.cfg.monitor_select == MUX_AMP3_R;
      case (st.cfg.monitor_select)
         MUX_GND:    nx.out.src = SRC_GND;
         MUX_SUPPLY: nx.out.src = SRC_SUPPLY;
         MUX_TEMP:   nx.out.src = SRC_TEMP;
         MUX_REF:    nx.out.src = SRC_REF;
         MUX_AMP1:   nx.out.src = SRC_AMP1;
         MUX_AMP2:   nx.out.src = SRC_AMP2;
         default: begin
            nx.out.src = st.amp.backemf_enable ? SRC_BEMF : SRC_AMP3;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st         <= '0;
         st.s1      <= '{strobe_n: 1'b1, default: '0};
         st.s2      <= '{strobe_n: 1'b1, default: '0};
         st.strobe_q <= 1'b1;
         st.amp     <= AMP_CTRL_RST;
         st.cfg     <= SENSE_RST;
         st.pending <= PENDING_RST;
         st.cst     <= CAL_IDLE;
         st.wait_r  <= 1'b1;
         st.out.sw12 <= 3'h7;
         st.out.src <= SRC_GND;
      end else begin
         st <= nx;
      end
   end

   assign avs_readdata_o              = st.rdata;
   assign avs_waitrequest_o           = st.wait_r;
   assign amp_enable_o                = st.out.amp_en;
   assign amp_gain_sel_o              = st.out.gain;
   assign sample_switch_o             = st.out.sample_sw;
   assign shunt_switch_o              = st.out.sw12;
   assign ground_switch_o             = st.out.sw34;
   assign autozero_o                  = st.out.autozero;
   assign comparator_enable_o         = st.out.cmp_en;
   assign comparator_threshold_o      = st.out.cmp_th;
   assign overcurrent_threshold_sel_o = st.out.oc_th;
   assign monitor_source_o            = st.out.src;
   assign monitor_series_res_o        = st.out.series_res;
   assign floating_phase_o            = st.out.phase;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);

   property p_enable_follows;
      !st.amp.enable[0] |=> !amp_enable_o[0];
   endproperty
   a_enable_follows: assert property (p_enable_follows)
      else $error("amplifier one still enabled after its bit cleared");

   property p_cmp_off;
      st.cfg.cmp_th[1] == CMP_TH_OFF |=> !comparator_enable_o[1];
   endproperty
   a_cmp_off: assert property (p_cmp_off)
      else $error("comparator two enabled with zero threshold");

   property p_gain_out;
      $changed(st.amp.gain) |=> amp_gain_sel_o == $past(st.amp.gain);
   endproperty
   a_gain_out: assert property (p_gain_out)
      else $error("gain output does not follow gain field");

   property p_sample_cause;
      sample_switch_o[0] |->
         $past(!st.s2.strobe_n && st.amp.sh_en[0] && st.amp.enable[0]);
   endproperty
   a_sample_cause: assert property (p_sample_cause)
      else $error("sample switch closed without strobe and enable");

   property p_bemf_blocks;
      st.amp.backemf_enable |=> !sample_switch_o[2];
   endproperty
   a_bemf_blocks: assert property (p_bemf_blocks)
      else $error("amplifier three sampled while back-EMF enabled");

   property p_amp3_route;
      (st.cfg.monitor_select == MUX_AMP3 && !st.amp.backemf_enable)
         |=> monitor_source_o == SRC_AMP3 && !monitor_series_res_o;
   endproperty
   a_amp3_route: assert property (p_amp3_route)
      else $error("amplifier three not routed to the pin");

   property p_cal_starts;
      (rstn_i && st.cst == CAL_IDLE && st.pending != 3'h0
       && !st.s2.sleep)
         |=> st.cst == CAL_RUN ##1 autozero_o != 3'h0;
   endproperty
   a_cal_starts: assert property (p_cal_starts)
      else $error("pending calibration did not start");

   property p_cal_switches;
      autozero_o[0] |-> shunt_switch_o[0] != ground_switch_o[0];
   endproperty
   a_cal_switches: assert property (p_cal_switches)
      else $error("input switches inconsistent during auto-zero");

   property p_cal_length;
      (st.cst == CAL_RUN && st.cnt == CAL_LAST) |=> st.cst == CAL_IDLE;
   endproperty
   a_cal_length: assert property (p_cal_length)
      else $error("calibration did not end at its length");

   property p_oc_sticky;
      st.s2.oc[0] && !st.s2.sleep |=> st.oc_flag[0];
   endproperty
   a_oc_sticky: assert property (p_oc_sticky)
      else $error("overcurrent event lost");

   property p_mux_supply;
      st.cfg.monitor_select == MUX_SUPPLY |=> monitor_source_o == SRC_SUPPLY;
   endproperty
   a_mux_supply: assert property (p_mux_supply)
      else $error("supply monitor not selected");

endmodule

// ===== src/sense_ctrl_pkg.sv
package sense_ctrl_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ        = 200;
   localparam int CAL_TIME_US    = 288;
   localparam int CAL_CYCLES_DEF = CAL_TIME_US * CLK_MHZ;
   localparam int CAL_CNT_W      = 17;

   // ------------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------------
   localparam int          ADDR_W       = 5;
   localparam logic [4:0]  OFS_AMP_CTRL = 5'h00;
   localparam logic [4:0]  OFS_SENSE    = 5'h04;
   localparam logic [4:0]  OFS_CAL      = 5'h08;
   localparam logic [4:0]  OFS_STATUS   = 5'h0C;
   localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;

   // ------------------------------------------------------------------
   // Codes
   // ------------------------------------------------------------------
   localparam logic [1:0] GAIN_X5  = 2'h0;
   localparam logic [1:0] GAIN_X10 = 2'h1;
   localparam logic [1:0] GAIN_X20 = 2'h2;
   localparam logic [1:0] GAIN_X40 = 2'h3;

   localparam logic [2:0] MUX_GND    = 3'h0;
   localparam logic [2:0] MUX_SUPPLY = 3'h1;
   localparam logic [2:0] MUX_TEMP   = 3'h2;
   localparam logic [2:0] MUX_REF    = 3'h3;
   localparam logic [2:0] MUX_AMP3_R = 3'h4;
   localparam logic [2:0] MUX_AMP1   = 3'h5;
   localparam logic [2:0] MUX_AMP2   = 3'h6;
   localparam logic [2:0] MUX_AMP3   = 3'h7;

   localparam logic [3:0] CMP_TH_OFF  = 4'h0;
   localparam logic [1:0] PHASE_A     = 2'h0;
   localparam logic [1:0] PHASE_B     = 2'h1;
   localparam logic [1:0] PHASE_C     = 2'h2;
   localparam logic [2:0] PENDING_RST = 3'h7;
   localparam logic [1:0] AMP3_IDX    = 2'h2;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      SRC_GND, SRC_SUPPLY, SRC_TEMP, SRC_REF,
      SRC_AMP1, SRC_AMP2, SRC_AMP3, SRC_BEMF
   } pin_src_t;

   typedef enum logic {CAL_IDLE, CAL_RUN} cal_state_t;

   typedef struct packed {
      logic [2:0][1:0] gain;
      logic            cal_connect;
      logic            backemf_enable;
      logic [2:0]      sh_en;
      logic [2:0]      enable;
   } amp_ctrl_t;

   typedef struct packed {
      logic [2:0][3:0] cmp_th;
      logic [1:0]      oc_th;
      logic            phase_src;
      logic [2:0]      monitor_select;
   } sense_cfg_t;

   typedef struct packed {
      logic       sleep;
      logic [2:0] li;
      logic [2:0] hi;
      logic [2:0] oc;
      logic [2:0] cmp;
      logic       strobe_n;
   } sync_t;

   typedef struct packed {
      logic [2:0]      amp_en;
      logic [2:0][1:0] gain;
      logic [2:0]      sample_sw;
      logic [2:0]      sw12;
      logic [2:0]      sw34;
      logic [2:0]      autozero;
      logic [2:0]      cmp_en;
      logic [2:0][3:0] cmp_th;
      logic [1:0]      oc_th;
      pin_src_t        src;
      logic            series_res;
      logic [1:0]      phase;
   } out_t;

   typedef struct packed {
      sync_t      s1;
      sync_t      s2;
      logic       strobe_q;
      amp_ctrl_t  amp;
      sense_cfg_t cfg;
      logic [2:0] oc_flag;
      logic [1:0] phase;
      logic [2:0] pending;
      cal_state_t cst;
      logic [1:0] cur;
      logic [CAL_CNT_W-1:0] cnt;
      logic       wait_r;
      logic [31:0] rdata;
      out_t       out;
   } state_t;

   localparam amp_ctrl_t  AMP_CTRL_RST = 14'h0000;
   localparam sense_cfg_t SENSE_RST    = 18'h0_0000;

endpackage

// ===== bench/mcu_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Controller model: register master and sample strobe driver
// ----------------------------------------------------------------------
module mcu_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] readdata_i,
   input  wire logic        waitrequest_i,
   output logic      [4:0]  address_o,
   output logic             read_o,
   output logic             write_o,
   output logic      [31:0] writedata_o,
   output logic      [3:0]  byteenable_o,
   output logic             strobe_n_o
);
   initial begin
      address_o    = 5'h00;
      read_o       = 1'b0;
      write_o      = 1'b0;
      writedata_o  = 32'h0000_0000;
      byteenable_o = 4'h0;
      strobe_n_o   = 1'b1;
   end

   // Released lines show the inverse so that stale data never looks valid.
   // Calibration starts are issued whenever the bench asks.
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      wrb(a, d, 4'hF);
   endtask

   task automatic wrb(input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      address_o    <= a;
      writedata_o  <= d;
      byteenable_o <= be;
      write_o      <= 1'b1;
      do @(posedge clk_i); while (waitrequest_i !== 1'b0);
      write_o      <= 1'b0;
      writedata_o  <= ~d;
      address_o    <= ~a;
      @(posedge clk_i);
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      address_o    <= a;
      byteenable_o <= 4'hF;
      read_o       <= 1'b1;
      do @(posedge clk_i); while (waitrequest_i !== 1'b0);
      d = readdata_i;
      read_o       <= 1'b0;
      address_o    <= ~a;
      @(posedge clk_i);
   endtask

   // The strobe is held low for the whole wanted sampling window.
   task automatic strobe(input logic v);
      strobe_n_o <= v;
   endtask

   // Settling pause after a select change before the output is used.
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
   endtask
endmodule

// ===== bench/sense_amplifier_control_tb.sv
`timescale 1ns/1ps

module sense_amplifier_control_tb;
   import sense_ctrl_pkg::*;
   localparam int CALN = 20;
   localparam int SETTLE_CYC = 4 * CLK_MHZ + 1;
   localparam pin_src_t MTAB [8] = '{SRC_GND, SRC_SUPPLY, SRC_TEMP, SRC_REF,
                                     SRC_AMP3, SRC_AMP1, SRC_AMP2, SRC_AMP3};
   logic        core_clk = 1'b0;
   logic        rstn     = 1'b0;
   logic        sleep;
   logic [2:0]  cmp_out;
   logic [2:0]  oc_raw;
   logic [2:0]  hi_in;
   logic [2:0]  lo_in;
   logic [4:0]  adr;
   logic        rd_s, wr_s, wreq, stb_n, ser;
   logic [31:0] wdat, rdat, rv;
   logic [3:0]  ben;
   logic [2:0]  en, smp, shunt, gnd, az, cen;
   logic [5:0]  gain;
   logic [11:0] cth;
   logic [1:0]  ocs, phase;
   pin_src_t    src;
   int          fail_count = 0;
   int          checks = 0;
   int          cycles = 0;

   always #2.5 core_clk = ~core_clk;

   sense_amplifier_control #(.CAL_CYCLES(CALN)) i_dut (
      .core_clk_i(core_clk), .rstn_i(rstn), .avs_address_i(adr),
      .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wdat),
      .avs_byteenable_i(ben), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq), .sample_strobe_n_i(stb_n),
      .comparator_out_i(cmp_out), .overcurrent_raw_i(oc_raw),
      .high_in_i(hi_in), .low_in_i(lo_in), .sleep_i(sleep),
      .amp_enable_o(en), .amp_gain_sel_o(gain), .sample_switch_o(smp),
      .shunt_switch_o(shunt), .ground_switch_o(gnd), .autozero_o(az),
      .comparator_enable_o(cen), .comparator_threshold_o(cth),
      .overcurrent_threshold_sel_o(ocs), .monitor_source_o(src),
      .monitor_series_res_o(ser), .floating_phase_o(phase));

   mcu_model i_mcu (
      .clk_i(core_clk), .readdata_i(rdat), .waitrequest_i(wreq),
      .address_o(adr), .read_o(rd_s), .write_o(wr_s), .writedata_o(wdat),
      .byteenable_o(ben), .strobe_n_o(stb_n));

   // ---------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------
   task automatic chk(input string w, input logic [31:0] s,
                      input logic [31:0] e);
      checks++;
      if (s !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", w, e, s);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // Bounded wait, so a stuck sequencer shows as a mismatch, not a hang.
   task automatic wait_az(input logic [2:0] v);
      int n;
      n = 0;
      while (az !== v && n < 200) begin
         step(1);
         n++;
      end
      chk("autozero", 32'(az), 32'(v));
   endtask

   task automatic end_of_test();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------
   task automatic t_powerup();
      wait_az(3'b001);
      chk("gnd0", 32'(gnd[0]), 32'h1);
      chk("shunt0", 32'(shunt[0]), 32'h0);
      wait_az(3'b010);
      wait_az(3'b100);
      wait_az(3'b000);
      $display("test powerup done");
   endtask

   task automatic t_amp();
      for (int g = 0; g < 4; g++) begin
         i_mcu.wr(OFS_AMP_CTRL, 32'({2'(g), 2'(g), 2'(g), 8'h05}));
         step(2);
         chk("gain", 32'(gain), 32'({2'(g), 2'(g), 2'(g)}));
         chk("enable", 32'(en), 32'h5);
      end
      i_mcu.rd(OFS_AMP_CTRL, rv);
      chk("amp_ctrl", rv, 32'h0000_3F05);
      i_mcu.wrb(OFS_AMP_CTRL, 32'h0000_00FF, 4'h2);
      i_mcu.rd(OFS_AMP_CTRL, rv);
      chk("amp lane", rv, 32'h0000_0005);
      $display("test amp done");
   endtask

   task automatic t_sh();
      i_mcu.wr(OFS_AMP_CTRL, 32'h0000_001F);
      step(5);
      chk("sample idle", 32'(smp), 32'h0);
      i_mcu.strobe(1'b0);
      step(5);
      chk("sample", 32'(smp), 32'h3);
      i_mcu.wr(OFS_AMP_CTRL, 32'h0000_007F);
      step(2);
      chk("sample bemf", 32'(smp), 32'h3);
      i_mcu.wr(OFS_AMP_CTRL, 32'h0000_003F);
      step(2);
      chk("sample all", 32'(smp), 32'h7);
      i_mcu.strobe(1'b1);
      step(5);
      chk("sample off", 32'(smp), 32'h0);
      $display("test sample_hold done");
   endtask

   task automatic t_mux();
      for (int c = 0; c < 8; c++) begin
         i_mcu.wr(OFS_SENSE, 32'(c));
         step(2);
         chk("source", 32'(src), 32'(MTAB[c]));
         chk("series", 32'(ser), 32'(c == 4));
      end
      i_mcu.wr(OFS_AMP_CTRL, 32'h0000_0040);
      i_mcu.wr(OFS_SENSE, 32'h0000_0004);
      i_mcu.settle(SETTLE_CYC);
      chk("bemf src", 32'(src), 32'(SRC_BEMF));
      $display("test mux done");
   endtask

   task automatic t_cmp();
      i_mcu.wr(OFS_SENSE, 32'h0003_D420);
      step(2);
      chk("cmp_en", 32'(cen), 32'h6);
      chk("cmp_th", 32'(cth), 32'h0000_0F50);
      chk("oc_sel", 32'(ocs), 32'h2);
      oc_raw <= 3'b010;
      step(6);
      oc_raw <= 3'b000;
      i_mcu.rd(OFS_STATUS, rv);
      chk("oc flag", 32'(rv[5:3]), 32'h2);
      i_mcu.wr(OFS_STATUS, 32'h0000_0038);
      i_mcu.rd(OFS_STATUS, rv);
      chk("oc clear", 32'(rv[5:3]), 32'h0);
      $display("test comparators done");
   endtask

   task automatic t_cal();
      int n;
      i_mcu.wr(OFS_AMP_CTRL, 32'h0000_0087);
      i_mcu.wr(OFS_CAL, 32'h0000_0002);
      wait_az(3'b010);
      chk("shunt1", 32'(shunt[1]), 32'h1);
      chk("gnd1", 32'(gnd[1]), 32'h0);
      n = 0;
      while (az[1] === 1'b1 && n < 100) begin
         step(1);
         n++;
      end
      chk("cal len", 32'(n >= CALN - 2 && n <= CALN + 2), 32'h1);
      step(2);
      chk("cal one", 32'(az), 32'h0);
      i_mcu.wr(OFS_AMP_CTRL, 32'h0000_0007);
      i_mcu.wr(OFS_CAL, 32'h0000_0004);
      wait_az(3'b100);
      chk("gnd2", 32'(gnd[2]), 32'h1);
      chk("shunt2", 32'(shunt[2]), 32'h0);
      wait_az(3'b000);
      $display("test calibration done");
   endtask

   task automatic t_phase();
      i_mcu.wr(OFS_SENSE, 32'h0000_0008);
      cmp_out <= 3'b010;
      step(6);
      chk("phase cmp", 32'(phase), 32'(PHASE_B));
      cmp_out <= 3'b001;
      step(6);
      chk("phase cmp", 32'(phase), 32'(PHASE_C));
      i_mcu.wr(OFS_SENSE, 32'h0000_0000);
      hi_in <= 3'b100;
      lo_in <= 3'b010;
      step(5);
      i_mcu.strobe(1'b0);
      step(8);
      chk("phase auto", 32'(phase), 32'(PHASE_A));
      i_mcu.strobe(1'b1);
      hi_in <= 3'b100;
      lo_in <= 3'b001;
      step(6);
      chk("phase hold", 32'(phase), 32'(PHASE_A));
      i_mcu.strobe(1'b0);
      step(8);
      chk("phase auto", 32'(phase), 32'(PHASE_B));
      i_mcu.strobe(1'b1);
      $display("test phase done");
   endtask

   task automatic t_bus_sleep();
      i_mcu.wr(OFS_AMP_CTRL, 32'h0000_0003);
      i_mcu.wr(5'h10, 32'hFFFF_FFFF);
      i_mcu.rd(5'h10, rv);
      chk("unmapped", rv, RD_UNMAPPED);
      i_mcu.rd(OFS_AMP_CTRL, rv);
      chk("amp_ctrl", rv, 32'h0000_0003);
      sleep <= 1'b1;
      step(6);
      chk("sleep en", 32'(en), 32'h0);
      sleep <= 1'b0;
      wait_az(3'b001);
      wait_az(3'b000);
      $display("test bus_sleep done");
   endtask

   // ---------------------------------------------------------------------
   // Main sequence and hang guard
   // ---------------------------------------------------------------------
   always @(posedge core_clk) begin
      cycles++;
      if (cycles >= 20000) begin
         fail_count++;
         end_of_test();
      end
   end

   initial begin
      sleep   = 1'b0;
      cmp_out = 3'h0;
      oc_raw  = 3'h0;
      hi_in   = 3'h0;
      lo_in   = 3'h0;
      step(16);
      chk("wait rst", 32'(wreq), 32'h1);
      chk("shunt rst", 32'(shunt), 32'h7);
      chk("src rst", 32'(src), 32'(SRC_GND));
      rstn <= 1'b1;
      step(1);
      t_powerup();
      t_amp();
      t_sh();
      t_mux();
      t_cmp();
      t_cal();
      t_phase();
      t_bus_sleep();
      end_of_test();
   end
endmodule
